//--- include/loop_snap_pkg.sv
package loop_snap_pkg;
	// register offsets are word indexes, not byte addresses: byte address = 4 * index
	localparam logic [7:0] IDX_SNAP     = 8'h25;
	localparam logic [7:0] IDX_TR_B0    = 8'h2B;
	localparam logic [7:0] IDX_TR_B1    = 8'h2C;
	localparam logic [7:0] IDX_TR_B2    = 8'h2D;
	localparam logic [7:0] IDX_TR_B3    = 8'h2E;
	localparam logic [7:0] IDX_TR_B4    = 8'h2F;
	localparam logic [7:0] IDX_TR_TOP   = 8'h30;
	localparam logic [7:0] IDX_PT_B0    = 8'h34;
	localparam logic [7:0] IDX_PT_B1    = 8'h35;
	localparam logic [7:0] IDX_PT_TOP   = 8'h36;
	localparam logic [7:0] IDX_CE_B0    = 8'h39;
	localparam logic [7:0] IDX_CE_B1    = 8'h3A;
	localparam logic [7:0] IDX_CE_TOP   = 8'h3B;
	localparam int         SNAP_BIT     = 0;
	localparam int         TR_W         = 44;
	localparam int         PT_W         = 20;
	localparam int         CE_W         = 20;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;

	// one coherent loop sample
	typedef struct packed {
		logic [TR_W-1:0] timingAcc;
		logic [PT_W-1:0] pilotAcc;
		logic [CE_W-1:0] carrierErr;
	} loop_sample_t;

	// ahb-lite request side
	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic        hready;
	} ahb_req_t;
endpackage

//--- core/loop_snap_capture.sv
`timescale 1ns/1ps
`default_nettype none
module loop_snap_capture (
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       rstn,
	// live loop values and snapshot strobe
	input  wire loop_snap_pkg::loop_sample_t live,
	input  wire logic                       snapReq,
	// held copy
	output var  loop_snap_pkg::loop_sample_t hold
);
	import loop_snap_pkg::*;
	loop_sample_t held;
	loop_sample_t next_held;
	// the register drives the port, so the copy exists only here
	assign hold = held;
	// take the live sample only on a snapshot strobe, otherwise keep it
	always_comb begin
		next_held = held;
		if (snapReq) begin
			next_held = live;
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			held <= '0;
		end else begin
			held <= next_held;
		end
	end
endmodule
`default_nettype wire

//--- core/loop_status_regs.sv
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
// Function
// - timing accumulator bits 31:24, 39:32 and 43:40 read at 2Eh, 2Fh and low nibble of 30h.
// - timing accumulator bits 23:0 read at 2Bh to 2Dh, low byte first.
// - pilot accumulator bits 7:0, 15:8, 19:16 read at 34h, 35h and low nibble of 36h.
// - carrier average error bits 7:0, 15:8, 19:16 read at 39h, 3Ah and low nibble of 3Bh.
// - writing 1 to bit 0 at 25h refreshes all slices together; software snaps before reading.
// - bits 7:4 at 30h, 36h and 3Bh read zero.
module loop_status_regs (
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        rstn,
	// live loop quantities, same clock
	input  wire loop_snap_pkg::loop_sample_t live,
	// ahb-lite slave
	input  wire logic                        hsel,
	input  wire logic [31:0]                 haddr,
	input  wire logic [1:0]                  htrans,
	input  wire logic                        hwrite,
	input  wire logic [2:0]                  hsize,
	input  wire logic                        hready,
	input  wire logic [31:0]                 hwdata,
	output logic      [31:0]                 hrdata,
	output logic                             hreadyout,
	output logic                             hresp
);
	import loop_snap_pkg::*;

	typedef struct packed {
		logic         wrPend;
		logic [7:0]   wrIdx;
		logic [31:0]  rdata;
	} state_t;

	state_t       st;
	state_t       next_st;
	logic         accept;
	logic         snapReq;
	loop_sample_t snapHeld;
	loop_sample_t snapNow;

	// the slice map is drawn for these widths; other values would misplace bits
	if (TR_W != 44 || PT_W != 20 || CE_W != 20) begin : g_width_check
		$error("loop widths do not fit the slice map");
	end

	// byte view of the held sample
	function automatic logic [7:0] slice(input loop_sample_t s, input logic [7:0] idx);
		logic [7:0] v;
		v = 8'h00;
		if (idx == IDX_TR_B0) begin
			v = s.timingAcc[7:0];
		end else if (idx == IDX_TR_B1) begin
			v = s.timingAcc[15:8];
		end else if (idx == IDX_TR_B2) begin
			v = s.timingAcc[23:16];
		end else if (idx == IDX_TR_B3) begin
			v = s.timingAcc[31:24];
		end else if (idx == IDX_TR_B4) begin
			v = s.timingAcc[39:32];
		end else if (idx == IDX_TR_TOP) begin
			v = {4'h0, s.timingAcc[43:40]};
		end else if (idx == IDX_PT_B0) begin
			v = s.pilotAcc[7:0];
		end else if (idx == IDX_PT_B1) begin
			v = s.pilotAcc[15:8];
		end else if (idx == IDX_PT_TOP) begin
			v = {4'h0, s.pilotAcc[19:16]};
		end else if (idx == IDX_CE_B0) begin
			v = s.carrierErr[7:0];
		end else if (idx == IDX_CE_B1) begin
			v = s.carrierErr[15:8];
		end else if (idx == IDX_CE_TOP) begin
			v = {4'h0, s.carrierErr[19:16]};
		end
		return v;
	endfunction

	// address phase accepted when selected, the bus is ready and htrans is NONSEQ
	assign accept    = hsel && hready && (htrans == HTRANS_NONSEQ);
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = st.rdata;
	// snapshot strobe lands in the write data phase
	assign snapReq   = st.wrPend && (st.wrIdx == IDX_SNAP) && hwdata[SNAP_BIT];
	// a read addressed beside the snapshot data phase already sees the new sample
	assign snapNow   = snapReq ? live : snapHeld;

	// the held sample lives in the capture register alone
	loop_snap_capture u_cap (
		.clk     (clk),
		.rstn    (rstn),
		.live    (live),
		.snapReq (snapReq),
		.hold    (snapHeld)
	);

	// next state: read data registered at address phase, so zero wait states
	always_comb begin
		next_st        = st;
		next_st.wrPend = 1'b0;
		// only the snapshot write has an effect; status writes fall through
		if (accept) begin
			next_st.wrPend = hwrite;
			next_st.wrIdx  = haddr[9:2];
			next_st.rdata  = hwrite ? 32'h0000_0000 :
				{24'h00_0000, slice(snapNow, haddr[9:2])};
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// a snapshot command takes the live sample on the next edge
	property p_snap_take;
		@(posedge clk) disable iff (!rstn)
		snapReq |=> (snapHeld == $past(live));
	endproperty
	a_snap_take: assert property (p_snap_take) else $error("snapshot not captured");

	// without a command the held sample never moves
	property p_hold;
		@(posedge clk) disable iff (!rstn)
		!snapReq |=> $stable(snapHeld);
	endproperty
	a_hold: assert property (p_hold) else $error("held sample changed");

	// reserved nibble of top slices reads zero
	property p_reserved;
		@(posedge clk) disable iff (!rstn)
		(accept && !hwrite && (haddr[9:2] == IDX_TR_TOP || haddr[9:2] == IDX_PT_TOP
			|| haddr[9:2] == IDX_CE_TOP)) |=> (hrdata[7:4] == 4'h0);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits set");

	// timing top slice matches held bits 43:40
	property p_tr_top;
		@(posedge clk) disable iff (!rstn)
		(accept && !hwrite && haddr[9:2] == IDX_TR_TOP && !snapReq)
			|=> (hrdata[3:0] == snapHeld.timingAcc[43:40]);
	endproperty
	a_tr_top: assert property (p_tr_top) else $error("timing top wrong");

	// timing low byte
	property p_tr_low;
		@(posedge clk) disable iff (!rstn)
		(accept && !hwrite && haddr[9:2] == IDX_TR_B0 && !snapReq)
			|=> (hrdata[7:0] == snapHeld.timingAcc[7:0]);
	endproperty
	a_tr_low: assert property (p_tr_low) else $error("timing low wrong");

	// pilot middle byte
	property p_pilot;
		@(posedge clk) disable iff (!rstn)
		(accept && !hwrite && haddr[9:2] == IDX_PT_B1 && !snapReq)
			|=> (hrdata[7:0] == snapHeld.pilotAcc[15:8]);
	endproperty
	a_pilot: assert property (p_pilot) else $error("pilot byte wrong");

	// carrier low byte
	property p_carrier;
		@(posedge clk) disable iff (!rstn)
		(accept && !hwrite && haddr[9:2] == IDX_CE_B0 && !snapReq)
			|=> (hrdata[7:0] == snapHeld.carrierErr[7:0]);
	endproperty
	a_carrier: assert property (p_carrier) else $error("carrier byte wrong");

	// upper data bits always zero after a read
	property p_upper;
		@(posedge clk) disable iff (!rstn)
		(accept && !hwrite) |=> (hrdata[31:8] == 24'h00_0000);
	endproperty
	a_upper: assert property (p_upper) else $error("upper bits set");

	// timing bits 31:24
	property p_tr_b3;
		@(posedge clk) disable iff (!rstn)
		(accept && !hwrite && haddr[9:2] == IDX_TR_B3 && !snapReq)
			|=> (hrdata[7:0] == snapHeld.timingAcc[31:24]);
	endproperty
	a_tr_b3: assert property (p_tr_b3) else $error("timing byte 3 wrong");

	// timing bits 39:32
	property p_tr_b4;
		@(posedge clk) disable iff (!rstn)
		(accept && !hwrite && haddr[9:2] == IDX_TR_B4 && !snapReq)
			|=> (hrdata[7:0] == snapHeld.timingAcc[39:32]);
	endproperty
	a_tr_b4: assert property (p_tr_b4) else $error("timing byte 4 wrong");

	// timing bits 15:8
	property p_tr_b1;
		@(posedge clk) disable iff (!rstn)
		(accept && !hwrite && haddr[9:2] == IDX_TR_B1 && !snapReq)
			|=> (hrdata[7:0] == snapHeld.timingAcc[15:8]);
	endproperty
	a_tr_b1: assert property (p_tr_b1) else $error("timing byte 1 wrong");

	// timing bits 23:16
	property p_tr_b2;
		@(posedge clk) disable iff (!rstn)
		(accept && !hwrite && haddr[9:2] == IDX_TR_B2 && !snapReq)
			|=> (hrdata[7:0] == snapHeld.timingAcc[23:16]);
	endproperty
	a_tr_b2: assert property (p_tr_b2) else $error("timing byte 2 wrong");

	// pilot low byte
	property p_pilot_low;
		@(posedge clk) disable iff (!rstn)
		(accept && !hwrite && haddr[9:2] == IDX_PT_B0 && !snapReq)
			|=> (hrdata[7:0] == snapHeld.pilotAcc[7:0]);
	endproperty
	a_pilot_low: assert property (p_pilot_low) else $error("pilot low byte wrong");

	// pilot top nibble
	property p_pilot_top;
		@(posedge clk) disable iff (!rstn)
		(accept && !hwrite && haddr[9:2] == IDX_PT_TOP && !snapReq)
			|=> (hrdata[3:0] == snapHeld.pilotAcc[19:16]);
	endproperty
	a_pilot_top: assert property (p_pilot_top) else $error("pilot top wrong");

	// carrier middle byte
	property p_carrier_mid;
		@(posedge clk) disable iff (!rstn)
		(accept && !hwrite && haddr[9:2] == IDX_CE_B1 && !snapReq)
			|=> (hrdata[7:0] == snapHeld.carrierErr[15:8]);
	endproperty
	a_carrier_mid: assert property (p_carrier_mid) else $error("carrier mid wrong");

	// carrier top nibble
	property p_carrier_top;
		@(posedge clk) disable iff (!rstn)
		(accept && !hwrite && haddr[9:2] == IDX_CE_TOP && !snapReq)
			|=> (hrdata[3:0] == snapHeld.carrierErr[19:16]);
	endproperty
	a_carrier_top: assert property (p_carrier_top) else $error("carrier top wrong");

	// a status write leaves the held sample alone through its data phase
	property p_status_wr;
		@(posedge clk) disable iff (!rstn)
		(accept && hwrite && haddr[9:2] != IDX_SNAP) |=> ##1 $stable(snapHeld);
	endproperty
	a_status_wr: assert property (p_status_wr) else $error("status write moved sample");
endmodule
`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import loop_snap_pkg::*;
	// bus, loop and bench state
	logic         clk, rstn, hsel, hwrite, hreadyout, hresp;
	logic [31:0]  haddr, hwdata, hrdata;
	logic [1:0]   htrans;
	logic [2:0]   hsize;
	loop_sample_t live;
	int           nErrors, checked;
	wire          hready = hreadyout;
	localparam loop_sample_t P1 = '{44'hFED_CBA9_8765, 20'hF_1E2D, 20'hF_3C4B};
	localparam loop_sample_t P2 = '{44'h123_4567_89AB, 20'h5_A5A5, 20'hA_0F0F};
	localparam logic [7:0] SLICES [13] = '{IDX_TR_B0, IDX_TR_B1, IDX_TR_B2, IDX_TR_B3,
		IDX_TR_B4, IDX_TR_TOP, IDX_PT_B0, IDX_PT_B1, IDX_PT_TOP, IDX_CE_B0, IDX_CE_B1,
		IDX_CE_TOP, IDX_SNAP};

	loop_status_regs DUT (.clk(clk), .rstn(rstn), .live(live), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

	// free-running 125 MHz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// expected byte of one slice, worked out from the held sample
	function automatic logic [31:0] expSlice(input logic [7:0] idx, input loop_sample_t s);
		logic [7:0] b;
		case (idx)
			IDX_TR_B0:  b = s.timingAcc[7:0];
			IDX_TR_B1:  b = s.timingAcc[15:8];
			IDX_TR_B2:  b = s.timingAcc[23:16];
			IDX_TR_B3:  b = s.timingAcc[31:24];
			IDX_TR_B4:  b = s.timingAcc[39:32];
			IDX_TR_TOP: b = {4'h0, s.timingAcc[43:40]};
			IDX_PT_B0:  b = s.pilotAcc[7:0];
			IDX_PT_B1:  b = s.pilotAcc[15:8];
			IDX_PT_TOP: b = {4'h0, s.pilotAcc[19:16]};
			IDX_CE_B0:  b = s.carrierErr[7:0];
			IDX_CE_B1:  b = s.carrierErr[15:8];
			IDX_CE_TOP: b = {4'h0, s.carrierErr[19:16]};
			default:    b = 8'h00;
		endcase
		return {24'h00_0000, b};
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			nErrors++;
			$display("BAD %0t read %h expected %h", $time, got, exp);
		end
	endtask

	task automatic stopTest();
		$display("compares %0d mismatches %0d", checked, nErrors);
		if (nErrors == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// one single ahb-lite transfer; called just after a rising edge
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		hsel <= 1'b1;
		haddr <= {22'h00_0000, idx, 2'b00};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		hsize <= HSIZE_WORD;
		n = 0;
		do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 50);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 100);
		rd = hrdata;
		if (n >= 50) begin
			nErrors++;
			$display("BAD %0t bus wait ran out", $time);
			stopTest();
		end
		check({31'h0, hresp}, 32'h0000_0000);
	endtask

	// reads every slice in turn, one idle cycle apart, against one sample
	task automatic readAll(input loop_sample_t s);
		logic [31:0] rd;
		foreach (SLICES[i]) begin
			xfer(1'b0, SLICES[i], 32'h0000_0000, rd);
			check(rd, expSlice(SLICES[i], s));
		end
	endtask

	task automatic testReset();
		readAll('0);
		$display("reset values done");
	endtask

	// live moves on right after the snapshot; slices must stay coherent
	task automatic testSnap();
		logic [31:0] rd;
		live <= P1;
		xfer(1'b1, IDX_SNAP, 32'h0000_0001, rd);
		live <= P2;
		readAll(P1);
		$display("snapshot done");
	endtask

	// writes to status slots and a zero snapshot bit change nothing
	task automatic testIgnore();
		logic [31:0] rd;
		foreach (SLICES[i]) xfer(1'b1, SLICES[i], 32'hFFFF_FFFE, rd);
		readAll(P1);
		xfer(1'b1, IDX_SNAP, 32'h0000_0001, rd);
		readAll(P2);
		$display("ignored writes done");
	endtask

	// reset in mid-run clears the held sample and the read data
	task automatic testMidReset();
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		check(hrdata, 32'h0000_0000);
		rstn <= 1'b1;
		readAll('0);
		$display("mid-run reset done");
	endtask

	initial begin
		nErrors = 0;
		checked = 0;
		rstn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = HSIZE_WORD;
		hwdata = 32'h0000_0000;
		live = '0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		testReset();
		testSnap();
		testIgnore();
		testMidReset();
		stopTest();
	end
endmodule
`default_nettype wire
